// >>> rtl/gpb_pkg.sv
// gpb_pkg: register map, port shapes, reset values and timing for the port bank
package gpb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GPB_OFS_DATA = 8'h00;
  localparam logic [7:0] GPB_OFS_OE = 8'h04;
  localparam logic [7:0] GPB_OFS_FS1 = 8'h08;
  localparam logic [7:0] GPB_OFS_FS2 = 8'h0C;
  localparam logic [7:0] GPB_OFS_FS3 = 8'h10;
  localparam logic [7:0] GPB_OFS_OD = 8'h28;
  localparam logic [7:0] GPB_OFS_PU = 8'h2C;
  localparam logic [7:0] GPB_OFS_PD = 8'h30;
  localparam logic [7:0] GPB_OFS_IE = 8'h38;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int GPB_PIN_LSB = 0;
  localparam int GPB_PIN_MSB = 7;
  localparam logic [7:0] GPB_RST_DATA = 8'h00;
  localparam logic [7:0] GPB_RST_OE = 8'h00;
  localparam logic [7:0] GPB_RST_FS = 8'h00;
  localparam logic [7:0] GPB_RST_OD = 8'h00;
  localparam logic [7:0] GPB_RST_PU = 8'h00;
  localparam logic [7:0] GPB_RST_PD = 8'h00;
  localparam logic [7:0] GPB_RST_IE = 8'h00;

  // ----------------------------------------------------------------
  // per-port shape, index 0..10 for the eleven ports
  // ----------------------------------------------------------------
  localparam int GPB_NUM_PORTS = 11;
  typedef logic [7:0] gpb_mask_t [GPB_NUM_PORTS];
  localparam gpb_mask_t GPB_PIN_MASK = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h03, 8'h01, 8'h3F, 8'h7F, 8'h3F, 8'h03};
  // input-only pins have no output driver bits
  localparam gpb_mask_t GPB_OUT_MASK = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h03, 8'h01, 8'h3F, 8'h7F, 8'h1F, 8'h03};
  localparam gpb_mask_t GPB_FS1_MASK = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h02, 8'h01, 8'h3F, 8'h7F, 8'h3F, 8'h03};
  localparam gpb_mask_t GPB_FS2_MASK = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'hFC, 8'h00, 8'h01, 8'h2D, 8'h45, 8'h34, 8'h00};
  localparam gpb_mask_t GPB_FS3_MASK = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h08, 8'h00, 8'h00, 8'h24, 8'h44, 8'h00, 8'h00};
  // interrupt pins that carry the input noise filter
  localparam gpb_mask_t GPB_FLT_MASK = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h02, 8'h01, 8'h00, 8'h00, 8'h04, 8'h01};

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int GPB_CLK_PS = 5000;
  localparam int GPB_FILT_NS = 30;
  localparam int GPB_FILT_CYC = (GPB_FILT_NS * 1000 + GPB_CLK_PS - 1) /
    GPB_CLK_PS;

endpackage

// >>> rtl/gpb_port.sv
// gpb_port: one general-purpose port with wishbone registers and pin logic
// What this block does
// - data register bits 7-0 read/write, drive the pins as port outputs
// - every register is 32 bits, unimplemented upper bits read zero
// - implemented bits and function registers depend on the chosen port
// - output enable bit one turns on the pin driver, zero turns it off
// - input enable has its own register, separate from output enable
// - input enable bit one passes the pin input, zero blocks it
// - one function register per function; one routes pin to function
// - open-drain bit with output one turns the driver off
// - pull-up bit one enables the pin pull-up
// - pull-down bit one enables the pin pull-down
// - filtered interrupt pins reject pulses shorter than about 30 ns
// - interrupt input active when input enabled, except in stop mode
// - writes to unimplemented bits do nothing, those bits read zero
`timescale 1ns/1ps
`default_nettype none

module gpb_port #(
  parameter int PORT_ID = 0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stop_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] pulldown_en_o,
  input wire logic [7:0] fn1_dout_i,
  input wire logic [7:0] fn2_dout_i,
  input wire logic [7:0] fn3_dout_i,
  output logic [7:0] fn1_sel_o,
  output logic [7:0] fn2_sel_o,
  output logic [7:0] fn3_sel_o,
  output logic [7:0] pin_in_o,
  output logic [7:0] int_o
);

  localparam logic [7:0] PMASK = gpb_pkg::GPB_PIN_MASK[PORT_ID];
  localparam logic [7:0] OMASK = gpb_pkg::GPB_OUT_MASK[PORT_ID];
  localparam logic [7:0] F1MASK = gpb_pkg::GPB_FS1_MASK[PORT_ID];
  localparam logic [7:0] F2MASK = gpb_pkg::GPB_FS2_MASK[PORT_ID];
  localparam logic [7:0] F3MASK = gpb_pkg::GPB_FS3_MASK[PORT_ID];
  localparam logic [7:0] FMASK = gpb_pkg::GPB_FLT_MASK[PORT_ID];
  localparam int FCYC = gpb_pkg::GPB_FILT_CYC;
  localparam logic [3:0] FCNT_MAX = 4'(FCYC - 1);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] data_q, oe_q, fs1_q, fs2_q, fs3_q, od_q, pu_q, pd_q, ie_q;
  logic [7:0] next_data, next_oe, next_fs1, next_fs2, next_fs3;
  logic [7:0] next_od, next_pu, next_pd, next_ie;
  logic [31:0] next_rdat;
  logic next_ack;
  logic wr_en;
  logic [7:0] wd;
  logic [7:0] sync1, sync2, flt, any_fn, rd_data;

  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign wd = wb_dat_i[gpb_pkg::GPB_PIN_MSB:gpb_pkg::GPB_PIN_LSB];
  assign any_fn = fs1_q | fs2_q | fs3_q;
  // port-mode pins with input open show the live pin, others the latch
  assign rd_data = (ie_q & ~any_fn & sync2) | (~(ie_q & ~any_fn) & data_q);

  always_comb begin
    next_data = data_q;
    next_oe = oe_q;
    next_fs1 = fs1_q;
    next_fs2 = fs2_q;
    next_fs3 = fs3_q;
    next_od = od_q;
    next_pu = pu_q;
    next_pd = pd_q;
    next_ie = ie_q;
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_rdat = '0;
    if (wr_en) begin
      // masks drop writes to bits this port does not have
      case (wb_adr_i)
        gpb_pkg::GPB_OFS_DATA: next_data = wd & PMASK;
        gpb_pkg::GPB_OFS_OE: next_oe = wd & OMASK;
        gpb_pkg::GPB_OFS_FS1: next_fs1 = wd & F1MASK;
        gpb_pkg::GPB_OFS_FS2: next_fs2 = wd & F2MASK;
        gpb_pkg::GPB_OFS_FS3: next_fs3 = wd & F3MASK;
        gpb_pkg::GPB_OFS_OD: next_od = wd & OMASK;
        gpb_pkg::GPB_OFS_PU: next_pu = wd & OMASK;
        gpb_pkg::GPB_OFS_PD: next_pd = wd & OMASK;
        gpb_pkg::GPB_OFS_IE: next_ie = wd & PMASK;
        default: next_data = data_q;
      endcase
    end
    if (next_ack && !wb_we_i) begin
      // upper 24 bits stay zero; unmapped offsets read all zero
      case (wb_adr_i)
        gpb_pkg::GPB_OFS_DATA: next_rdat[7:0] = rd_data;
        gpb_pkg::GPB_OFS_OE: next_rdat[7:0] = oe_q;
        gpb_pkg::GPB_OFS_FS1: next_rdat[7:0] = fs1_q;
        gpb_pkg::GPB_OFS_FS2: next_rdat[7:0] = fs2_q;
        gpb_pkg::GPB_OFS_FS3: next_rdat[7:0] = fs3_q;
        gpb_pkg::GPB_OFS_OD: next_rdat[7:0] = od_q;
        gpb_pkg::GPB_OFS_PU: next_rdat[7:0] = pu_q;
        gpb_pkg::GPB_OFS_PD: next_rdat[7:0] = pd_q;
        gpb_pkg::GPB_OFS_IE: next_rdat[7:0] = ie_q;
        default: next_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= gpb_pkg::GPB_RST_DATA;
      oe_q <= gpb_pkg::GPB_RST_OE;
      fs1_q <= gpb_pkg::GPB_RST_FS;
      fs2_q <= gpb_pkg::GPB_RST_FS;
      fs3_q <= gpb_pkg::GPB_RST_FS;
      od_q <= gpb_pkg::GPB_RST_OD;
      pu_q <= gpb_pkg::GPB_RST_PU;
      pd_q <= gpb_pkg::GPB_RST_PD;
      ie_q <= gpb_pkg::GPB_RST_IE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      data_q <= next_data;
      oe_q <= next_oe;
      fs1_q <= next_fs1;
      fs2_q <= next_fs2;
      fs3_q <= next_fs3;
      od_q <= next_od;
      pu_q <= next_pu;
      pd_q <= next_pd;
      ie_q <= next_ie;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
    end
  end

  // ----------------------------------------------------------------
  // pin output path
  // ----------------------------------------------------------------
  logic [7:0] out_val;
  // fn1 wins if software breaks the one-function-per-pin limit
  assign out_val = (fs1_q & fn1_dout_i) | (~fs1_q & fs2_q & fn2_dout_i) |
    (~fs1_q & ~fs2_q & fs3_q & fn3_dout_i) | (~any_fn & data_q);
  assign pin_o = out_val;
  assign pin_oe_o = oe_q & ~(od_q & out_val);
  assign pullup_en_o = pu_q;
  assign pulldown_en_o = pd_q;
  assign fn1_sel_o = fs1_q;
  assign fn2_sel_o = fs2_q;
  assign fn3_sel_o = fs3_q;
  assign pin_in_o = sync2 & ie_q;
  // interrupt taps ignore function select; stop mode shuts them off
  assign int_o = flt & ie_q & FMASK & {8{~stop_i}};

  // ----------------------------------------------------------------
  // input synchroniser and noise filter, one slice per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic [3:0] cnt, next_cnt;
      logic next_flt;
      always_comb begin
        next_cnt = 4'h0;
        next_flt = flt[g];
        if (!FMASK[g]) begin
          next_flt = sync2[g];
        end else if (sync2[g] != flt[g]) begin
          // level must hold the whole window before it is believed
          if (cnt == FCNT_MAX) begin
            next_flt = sync2[g];
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          flt[g] <= 1'b0;
          cnt <= 4'h0;
        end else if (ce_i) begin
          sync1[g] <= pin_i[g];
          sync2[g] <= sync1[g];
          flt[g] <= next_flt;
          cnt <= next_cnt;
        end
      end
      a_filter_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (FMASK[g] && cnt != FCNT_MAX) |=> $stable(flt[g]))
        else $error("filtered input changed before window elapsed");
      a_filter_take: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (FMASK[g] && ce_i && cnt == FCNT_MAX && sync2[g] != flt[g])
        |=> flt[g] == $past(sync2[g]))
        else $error("filtered input not taken after window");
      a_cnt_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && sync2[g] == flt[g]) |=> cnt == 4'h0)
        else $error("filter window count not cleared");
      a_filter_pass: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!FMASK[g] && ce_i) |=> flt[g] == $past(sync2[g]))
        else $error("unfiltered input did not follow pin");
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_data_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_DATA)
    |=> data_q == ($past(wd) & PMASK))
    else $error("data register did not take written value");
  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (data_q & ~PMASK) == 8'h00 && (fs2_q & ~F2MASK) == 8'h00
    && (ie_q & ~PMASK) == 8'h00)
    else $error("unimplemented bit got set");
  a_oe_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_oe_o & ~oe_q) == 8'h00)
    else $error("driver on without output enable");
  a_od_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_oe_o & od_q & pin_o) == 8'h00 &&
    (pin_oe_o | od_q | ~oe_q) == 8'hFF)
    else $error("open-drain drive wrong");
  a_in_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_in_o & ~ie_q) == 8'h00)
    else $error("input passed while disabled");
  a_pull_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pullup_en_o == pu_q && pulldown_en_o == pd_q)
    else $error("pull enables do not follow registers");
  a_fn_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (fs1_q & (pin_o ^ fn1_dout_i)) == 8'h00)
    else $error("function pin not routed");
  a_irq_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_i |-> int_o == 8'h00)
    else $error("interrupt active in stop mode");
  a_read_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
    wb_adr_i == gpb_pkg::GPB_OFS_DATA) |=> wb_dat_o[7:0] == $past(rd_data))
    else $error("data read mismatch");
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wb_ack_o) && $stable(data_q) && $stable(oe_q)
    && $stable(ie_q) && $stable(sync2) && $stable(flt))
    else $error("state moved while clock enable low");
  a_oe_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_OE)
    |=> oe_q == ($past(wd) & OMASK))
    else $error("output enable did not take written value");
  a_ie_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_IE)
    |=> ie_q == ($past(wd) & PMASK))
    else $error("input enable did not take written value");
  a_od_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_OD)
    |=> od_q == ($past(wd) & OMASK))
    else $error("open-drain did not take written value");
  a_pu_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_PU)
    |=> pu_q == ($past(wd) & OMASK))
    else $error("pull-up did not take written value");
  a_pd_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_PD)
    |=> pd_q == ($past(wd) & OMASK))
    else $error("pull-down did not take written value");
  a_fs1_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_en && wb_adr_i == gpb_pkg::GPB_OFS_FS1)
    |=> fs1_q == ($past(wd) & F1MASK))
    else $error("function select did not take written value");
  a_sel_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    !wb_sel_i[0]) |=> $stable(data_q) && $stable(oe_q) && $stable(ie_q))
    else $error("write without byte enable changed a register");
  a_irq_live: assert property (@(posedge clk_i) disable iff (rst_i)
    !stop_i |-> int_o == (flt & ie_q & FMASK))
    else $error("interrupt tap does not follow enabled input");
  a_in_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_in_o == (sync2 & ie_q))
    else $error("input path does not follow enabled pin");

endmodule

`default_nettype wire

// >>> test/gpb_pad_model.sv
// gpb_pad_model: outside world of one port, resolves drivers and pulls
`timescale 1ns/1ps
`default_nettype none

module gpb_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_en_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pd_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  // a pad nobody holds wanders every cycle, so no stale level survives
  logic [7:0] wander = 8'h55;
  always_ff @(posedge clk_i) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_en_i[i]) level_o[i] = drv_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_i[i];
      else if (pu_i[i]) level_o[i] = 1'b1;
      else if (pd_i[i]) level_o[i] = 1'b0;
      else level_o[i] = wander[i];
    end
  end
endmodule

`default_nettype wire

// >>> test/gpb_port_bench.sv
// gpb_port_bench: random register, pin and filter checks for one port
`timescale 1ns/1ps
`default_nettype none

module gpb_port_bench;
  localparam int P = 10;
  localparam logic [7:0] PM = gpb_pkg::GPB_PIN_MASK[P];
  localparam logic [7:0] OM = gpb_pkg::GPB_OUT_MASK[P];
  localparam logic [7:0] FM = gpb_pkg::GPB_FLT_MASK[P];
  localparam logic [7:0] OFS [10] = '{gpb_pkg::GPB_OFS_DATA,
    gpb_pkg::GPB_OFS_OE, gpb_pkg::GPB_OFS_FS1, gpb_pkg::GPB_OFS_FS2,
    gpb_pkg::GPB_OFS_FS3, gpb_pkg::GPB_OFS_OD, gpb_pkg::GPB_OFS_PU,
    gpb_pkg::GPB_OFS_PD, gpb_pkg::GPB_OFS_IE, 8'h14};
  localparam logic [7:0] MSK [10] = '{PM, OM, gpb_pkg::GPB_FS1_MASK[P],
    gpb_pkg::GPB_FS2_MASK[P], gpb_pkg::GPB_FS3_MASK[P], OM, OM, OM, PM,
    8'h00};
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic stop = 1'b0, ack, ce = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, ext = 8'h00, ext_en = 8'h00;
  logic [7:0] fn1 = 8'h00, fn2 = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] po, poe, pu, pd, s1, s2, s3, pin_in, irq, lvl;
  logic [7:0] mreg [10];
  logic [7:0] xo, xoe, xl, kn, rdx, cm;
  int fails = 0;
  int n_tests = 0;

  initial forever #2.5 clk_i = ~clk_i;

  gpb_port #(.PORT_ID(P)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stop_i(stop), .pin_i(lvl), .pin_o(po), .pin_oe_o(poe),
    .pullup_en_o(pu), .pulldown_en_o(pd), .fn1_dout_i(fn1),
    .fn2_dout_i(fn2), .fn3_dout_i(~fn2), .fn1_sel_o(s1), .fn2_sel_o(s2),
    .fn3_sel_o(s3), .pin_in_o(pin_in), .int_o(irq));
  gpb_pad_model pad (.clk_i(clk_i), .drv_i(po), .drv_en_i(poe),
    .pu_i(pu), .pd_i(pd), .ext_i(ext), .ext_en_i(ext_en), .level_o(lvl));

  // ----------------------------------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) begin
      fails++;
      wrap_up();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input int k, input logic [31:0] v, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, OFS[k], v, s, q);
    if (s[0]) mreg[k] = v[7:0] & MSK[k];
  endtask

  // float bits (no driver, no pull) are left out of the pin comparisons
  task automatic check_all();
    logic [31:0] q;
    logic [7:0] rm, rx;
    xo = ((mreg[2] & fn1) | (~mreg[2] & mreg[0])) & PM;
    xoe = mreg[1] & ~(mreg[5] & xo);
    kn = xoe | ext_en | mreg[6] | mreg[7];
    xl = (xoe & xo) | (~xoe & ext_en & ext) | (~xoe & ~ext_en & mreg[6]);
    rdx = (mreg[8] & ~mreg[2] & xl) | (~(mreg[8] & ~mreg[2]) & mreg[0]);
    cm = ~(mreg[8] & ~mreg[2] & ~kn);
    @(negedge clk_i);
    chk(po, xo);
    chk(poe, xoe);
    chk(pu, mreg[6]);
    chk(pd, mreg[7]);
    chk({s3, s2, s1}, {mreg[4], mreg[3], mreg[2]});
    chk(pin_in & kn, xl & mreg[8] & kn);
    chk(irq & kn, xl & mreg[8] & FM & {8{~stop}} & kn);
    for (int k = 0; k < 10; k++) begin
      wb(1'b0, OFS[k], 32'h0, 4'hF, q);
      rm = (k == 0) ? cm : 8'hFF;
      rx = (k == 0) ? rdx : mreg[k];
      chk(q & {24'hFFFFFF, rm}, {24'h0, rx & rm});
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    v = $urandom(20);
    for (int k = 0; k < 10; k++) mreg[k] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all();
    for (int r = 0; r < 30; r++) begin
      @(posedge clk_i);
      ext <= 8'($urandom);
      ext_en <= 8'($urandom);
      fn1 <= 8'($urandom);
      fn2 <= 8'($urandom);
      stop <= 1'($urandom);
      for (int k = 0; k < 10; k++) wr(k, $urandom, 4'($urandom));
      repeat (12) @(posedge clk_i);
      check_all();
    end
    // function routed on the filter pin, interrupt must still follow
    wr(1, 32'h0, 4'h1);
    wr(2, 32'h1, 4'h1);
    wr(8, 32'h3, 4'h1);
    @(posedge clk_i);
    ext_en <= 8'hFF;
    ext <= 8'h00;
    stop <= 1'b0;
    repeat (12) @(posedge clk_i);
    // clock enable low: a pin change must not reach the input path
    ce <= 1'b0;
    ext <= 8'h03;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk(pin_in, 8'h00);
    chk(irq, 8'h00);
    @(posedge clk_i);
    ce <= 1'b1;
    ext <= 8'h00;
    repeat (12) @(posedge clk_i);
    ext <= 8'h01;
    repeat (3) @(posedge clk_i);
    ext <= 8'h00;
    repeat (14) begin
      @(negedge clk_i);
      chk(irq, 8'h00);
    end
    @(posedge clk_i);
    ext <= 8'h01;
    repeat (12) @(posedge clk_i);
    check_all();
    stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_all();
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    wrap_up();
  end
endmodule

`default_nettype wire
